// File: bench/sram_chk.sv
// pin-level assertions for the byte-masked sram core
`timescale 1ns/100ps
`default_nettype none
module sram_chk
  import ddr_sram_pkg::*;
(
  // watched pins
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              k_in,
  input wire logic              k_n_in,
  input wire logic              read_not_write_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_out,
  input wire logic              buf_ready_out
);
  logic [3:0] age;
  logic [1:0] kq;
  // age counts cycles since either clock pin last moved
  always_ff @(posedge sys_clk_in) begin
    kq  <= {k_in, k_n_in};
    age <= (kq != {k_in, k_n_in}) ? 4'h0 : age + {3'h0, age != 4'hf};
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_rst_quiet;
    disable iff (1'b0) rst_in |=> !dq_oe_out;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("data pins driven after reset");
  property p_rst_zero;
    disable iff (1'b0) rst_in |=> dq_out == '0;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("read data not cleared by reset");
  property p_room;
    buf_ready_out;
  endproperty
  a_room: assert property (p_room)
    else $error("beat buffer refused at legal rate");
  property p_oe_on;
    $rose(dq_oe_out) |-> k_n_in && !k_in;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("first word not launched on complement rise");
  property p_oe_off;
    $fell(dq_oe_out) |-> k_n_in;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("pins released off the complement rise");
  property p_word_tick;
    $changed(dq_out) |-> age inside {[1:4]};
  endproperty
  a_word_tick: assert property (p_word_tick)
    else $error("read word changed away from a clock rise");
  property p_oe_tick;
    $changed(dq_oe_out) |-> age inside {[1:4]};
  endproperty
  a_oe_tick: assert property (p_oe_tick)
    else $error("output enable moved away from a clock rise");
  property p_rd_only;
    $rose(dq_oe_out) |-> read_not_write_in;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("pins driven during a write");
endmodule
`default_nettype wire

// File: bench/sram_ctl.sv
// controller model: drives two-word bursts onto the sram pins
`timescale 1ns/100ps
`default_nettype none
module sram_ctl
  import ddr_sram_pkg::*;
(
  // clock and wire level
  input  wire logic                 sys_clk_in,
  input  wire logic [DATA_W-1:0]    dq_in,
  input  wire logic                 dq_oe_in,
  // controller pins
  output logic                      k_out,
  output logic                      k_n_out,
  output logic                      load_strobe_n_out,
  output logic                      read_not_write_out,
  output logic [ADDR_W-1:0]         addr_out,
  output logic [MAX_LANES-1:0]      byte_lane_mask_n_out,
  output logic [DATA_W-1:0]         dq_out
);
  initial begin
    k_out = 1'b1;  // stopped clocks parked high
    k_n_out = 1'b1;
    load_strobe_n_out = 1'b1;
    read_not_write_out = 1'b1;
    addr_out = '0;
    byte_lane_mask_n_out = '1;
    dq_out = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic edge_to(input logic v);
    k_out   <= v;
    k_n_out <= !v;
    hold(3);
  endtask
  task automatic cmd(input logic rnw, input logic [ADDR_W-1:0] a);
    k_out <= 1'b0;
    hold(3);
    load_strobe_n_out  <= 1'b0;  // load low, direction set
    read_not_write_out <= rnw;
    addr_out           <= a;
    hold(3);
    edge_to(1'b1);
    load_strobe_n_out <= 1'b1;
    addr_out          <= ~a;
    hold(3);
  endtask
  task automatic beat(input logic v, input logic [DATA_W-1:0] d,
                      input logic [MAX_LANES-1:0] m);
    edge_to(v);
    dq_out               <= d;
    byte_lane_mask_n_out <= m;
    hold(3);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
    input logic [MAX_LANES-1:0] m0, input logic [DATA_W-1:0] d1,
    input logic [MAX_LANES-1:0] m1);
    cmd(1'b0, a);
    beat(1'b0, d0, m0);
    beat(1'b1, d1, m1);  // own pattern on each beat
    // released pins flip so stale data cannot match by luck
    beat(1'b0, ~d1, ~m1);
    k_out <= 1'b1;
    hold(6);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output int n,
    output logic [DATA_W-1:0] w0, output logic [DATA_W-1:0] w1);
    n = 0;
    cmd(1'b1, a);
    for (int i = 0; i < 8; i++) begin
      edge_to(logic'(i[0]));
      hold(2);
      if (dq_oe_in === 1'b1) begin
        if (n == 0) w0 = dq_in;
        if (n == 1) w1 = dq_in;
        n++;
      end
      hold(1);
    end
    k_n_out <= 1'b1;
    hold(6);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// bench: bursts through the controller model against a lane model
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ddr_sram_pkg::*;
;
  logic                sys_clk_in;
  logic                rst_in;
  wire                 k, kn, ld, rnw, oe, rdy;
  wire [ADDR_W-1:0]    ad;
  wire [MAX_LANES-1:0] msk;
  wire [DATA_W-1:0]    cd, q, dq;
  logic [DATA_W-1:0]   mdl [256];
  int                  num_errors = 0;
  int                  checks_done = 0;
  int                  cyc = 0;
  assign dq = oe ? q : cd;
  ddr_sram_byte_write_mask i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .k_in(k), .k_n_in(kn), .load_strobe_n_in(ld), .read_not_write_in(rnw),
    .addr_in(ad), .byte_lane_mask_n_in(msk), .dq_in(dq), .dq_out(q),
    .dq_oe_out(oe), .buf_ready_out(rdy));
  sram_ctl i_ctl (.sys_clk_in(sys_clk_in), .dq_in(dq), .dq_oe_in(oe),
    .k_out(k), .k_n_out(kn), .load_strobe_n_out(ld),
    .read_not_write_out(rnw), .addr_out(ad), .byte_lane_mask_n_out(msk),
    .dq_out(cd));
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [DATA_W-1:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, d,
    input logic [MAX_LANES-1:0] m);
    for (int i = 0; i < MAX_LANES; i++)
      if (!m[i]) o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    return o;
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
    input logic [MAX_LANES-1:0] m0, input logic [DATA_W-1:0] d1,
    input logic [MAX_LANES-1:0] m1);
    i_ctl.wr(a, d0, m0, d1, m1);
    mdl[a] = mrg(mdl[a], d0, m0);
    mdl[ADDR_W'(a + 1)] = mrg(mdl[ADDR_W'(a + 1)], d1, m1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    logic [DATA_W-1:0] w0, w1;
    i_ctl.rd(a, n, w0, w1);
    check("words", DATA_W'(n), 36'h2);
    check("word0", w0, mdl[a]);
    check("word1", w1, mdl[ADDR_W'(a + 1)]);
  endtask
  task automatic t_reset;
    check("oe", DATA_W'(oe), '0);
    check("q", q, '0);
  endtask
  task automatic t_full;
    wr(8'h10, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0);
    rd(8'h10);
  endtask
  task automatic t_lanes;
    wr(8'h40, '0, 4'h0, '1, 4'h0);
    for (int n = 0; n < MAX_LANES; n++) begin
      wr(8'h40, 36'h5a5a5a5a5 ^ DATA_W'(n), ~(4'h1 << n), 36'ha5a5a5a5a,
         ~(4'h8 >> n));
      rd(8'h40);
    end
  endtask
  task automatic t_none;
    wr(8'h40, '1, 4'hf, '0, 4'hf);
    rd(8'h40);
  endtask
  task automatic t_wrap;
    wr(8'hff, 36'h0abcdef01, 4'h0, 36'h013579246, 4'h0);
    rd(8'hff);
  endtask
  initial begin
    rst_in = 1'b1;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    t_reset();
    t_full();
    t_lanes();
    t_none();
    t_wrap();
    close_out();
  end
endmodule
bind ddr_sram_byte_write_mask sram_chk i_chk (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .k_in(k_in), .k_n_in(k_n_in),
  .read_not_write_in(read_not_write_in), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .buf_ready_out(buf_ready_out));
`default_nettype wire

// File: verilog/ddr_sram_byte_write_mask.sv
// byte-masked ddr sram core: pin capture, beat buffer and masked array
`timescale 1ns/100ps
`default_nettype none

module beat_fifo
  import ddr_sram_pkg::*;
#(
  parameter int WIDTH = $bits(beat_t),
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    in_ready_out  = (count != (PW+1)'(DEPTH));
    out_valid_out = (count != '0);
    out_data_out  = store[rd_ptr];
    push          = in_valid_in && in_ready_out;
    pop           = out_valid_out && out_ready_in;
    next_wr_ptr   = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr   = pop ? bump(rd_ptr) : rd_ptr;
    next_count    = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset; only slots filled by a push are ever popped
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end
endmodule

module ddr_sram_byte_write_mask
  import ddr_sram_pkg::*;
#(
  parameter int LANES = MAX_LANES
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // input clock pair from the controller
  input  wire logic              k_in,
  input  wire logic              k_n_in,
  // command pins
  input  wire logic              load_strobe_n_in,
  input  wire logic              read_not_write_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [MAX_LANES-1:0] byte_lane_mask_n_in,
  // two-way data pins
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_out,
  // status
  output logic                   buf_ready_out
);
  // every pin passes two flops; a third copy of each clock finds edges
  logic [2:0]            k_sync;
  logic [2:0]            kn_sync;
  logic [1:0]            ld_n_sync;
  logic [1:0]            rnw_sync;
  logic [ADDR_W-1:0]     addr_s1;
  logic [ADDR_W-1:0]     addr_s2;
  logic [MAX_LANES-1:0]  sel_s1;
  logic [MAX_LANES-1:0]  sel_s2;
  logic [DATA_W-1:0]     dq_s1;
  logic [DATA_W-1:0]     dq_s2;

  always_ff @(posedge sys_clk_in) begin
    k_sync    <= {k_sync[1:0], k_in};
    kn_sync   <= {kn_sync[1:0], k_n_in};
    ld_n_sync <= {ld_n_sync[0], load_strobe_n_in};
    rnw_sync  <= {rnw_sync[0], read_not_write_in};
    addr_s1   <= addr_in;
    addr_s2   <= addr_s1;
    sel_s1    <= byte_lane_mask_n_in;
    sel_s2    <= sel_s1;
    dq_s1     <= dq_in;
    dq_s2     <= dq_s1;
  end

  logic k_rise;
  logic kn_rise;
  assign k_rise  = k_sync[1] && !k_sync[2];   // [R05]
  assign kn_rise = kn_sync[1] && !kn_sync[2]; // [R05]

  // lanes beyond LANES never write, so the narrow word uses bits 17:0
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [MAX_LANES-1:0] sel_n
  );
    lane_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_mask[i*LANE_W +: LANE_W] = {LANE_W{!sel_n[i]}}; // [R13] [R01] [R03]
    end
  endfunction

  // array read is combinational so the word lands in the edge's cycle
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // burst sequencer
  burst_state_t      state;
  burst_state_t      next_state;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic [DATA_W-1:0] next_dq_out;
  logic              next_dq_oe;
  logic              beat_valid;
  beat_t             beat;
  logic              rd_fetch;
  logic [ADDR_W-1:0] rd_addr;

  always_comb begin
    next_state     = state;
    next_base_addr = base_addr;
    next_dq_out    = dq_out;
    next_dq_oe     = dq_oe_out;
    beat_valid     = 1'b0;
    beat.addr      = base_addr;
    beat.data      = dq_s2;
    beat.mask      = lane_mask(sel_s2); // [R06] pattern of this beat only
    rd_fetch       = 1'b0;
    rd_addr        = base_addr;
    case (state)
      ST_IDLE: begin
        if (k_rise && !ld_n_sync[1]) begin
          next_base_addr = addr_s2;
          next_state     = rnw_sync[1] ? ST_RD0 : ST_WR0; // [R11]
        end
      end
      ST_WR0: begin
        if (k_rise) begin
          beat_valid = 1'b1; // [R05] first beat on true clock
          next_state = ST_WR1;
        end
      end
      ST_WR1: begin
        if (kn_rise) begin
          beat_valid = 1'b1; // [R05] second beat on complement
          beat.addr  = base_addr + 1'b1; // [R08]
          next_state = ST_IDLE;
        end
      end
      ST_RD0: begin
        if (k_rise) begin
          next_state = ST_RD1;
        end
      end
      ST_RD1: begin
        if (k_rise) begin
          next_state = ST_RD2;
        end
      end
      ST_RD2: begin
        if (kn_rise) begin
          rd_fetch   = 1'b1;
          next_dq_oe = 1'b1; // [R09] word A on complement rise
          next_state = ST_RD3;
        end
      end
      ST_RD3: begin
        if (k_rise) begin
          rd_fetch   = 1'b1;
          rd_addr    = base_addr + 1'b1; // [R08] [R09] word A+1
          next_state = ST_RD4;
        end
      end
      ST_RD4: begin
        if (kn_rise) begin
          next_dq_oe = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_dq_oe = 1'b0;
      end
    endcase
    if (rd_fetch) begin
      next_dq_out = mem[rd_addr]; // [R09]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state     <= ST_IDLE;   // [R07] deselected
      base_addr <= '0;
      dq_out    <= '0;
      dq_oe_out <= 1'b0;      // [R07] pins released
    end else begin
      state     <= next_state;
      base_addr <= next_base_addr;
      dq_out    <= next_dq_out;
      dq_oe_out <= next_dq_oe;
    end
  end

  // beats wait here so an array write never collides with a read fetch
  logic  drain_valid;
  logic  drain_ready;
  beat_t drain_beat;

  assign drain_ready = !rd_fetch;

  beat_fifo #(
    .WIDTH ($bits(beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_beat_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (beat_valid),
    .in_ready_out  (buf_ready_out),
    .in_data_in    (beat),
    .out_valid_out (drain_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_beat)
  );

  // unmasked bits keep old contents, so partial writes need no rmw
  always_ff @(posedge sys_clk_in) begin
    if (drain_valid && drain_ready) begin
      mem[drain_beat.addr] <= (mem[drain_beat.addr] & ~drain_beat.mask)
                            | (drain_beat.data & drain_beat.mask); // [R12] [R02] [R04]
    end
  end

endmodule

`default_nettype wire

// File: verilog/ddr_sram_pkg.sv
// shared constants and types for the byte-masked ddr sram read and write paths
//
// Summary of operation
// [R01] narrow word: select n low writes lane n
// [R02] all four selects low writes full word
// [R03] wide word: select n gates lane n
// [R04] all selects high leaves array untouched
// [R05] beat data taken on true, complement rises
// [R06] each beat uses its own select pattern
// [R07] after reset: deselected, data pins released
// [R08] first word at A, second at A+1
// [R09] read words launched on both clock rises
// [R10] controller should park stopped clocks high
// [R11] write starts: load low, direction low
// [R12] unselected lane keeps its stored contents
// [R13] inverted selects form per-bit write mask
package ddr_sram_pkg;

  localparam int LANE_W    = 9;
  localparam int MAX_LANES = 4;
  localparam int DATA_W    = LANE_W * MAX_LANES;
  localparam int ADDR_W    = 8;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] mask;
  } beat_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WR0  = 8'h02,
    ST_WR1  = 8'h04,
    ST_RD0  = 8'h08,
    ST_RD1  = 8'h10,
    ST_RD2  = 8'h20,
    ST_RD3  = 8'h40,
    ST_RD4  = 8'h80
  } burst_state_t;

endpackage
